// ===== ssd_pkg.sv
// Constants, types and register map for the selection sequence status decode block.
// Assumes a 32-bit classic Wishbone bus with one register per aligned word.
package ssd_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [3:0] IDX_REASON = 4'h5;
	localparam logic [3:0] IDX_STEP = 4'h6;
	localparam logic [3:0] IDX_IRQ_STAT = 4'h8;
	localparam logic [3:0] IDX_IRQ_CLR = 4'h9;
	localparam logic [3:0] IDX_IRQ_EN = 4'hA;
	localparam int ADDR_LSB = 2;
	localparam int IDX_W = 4;
	// Interrupt reason codes.
	localparam logic [7:0] REASON_DISC = 8'h20;
	localparam logic [7:0] REASON_DONE = 8'h18;
	localparam logic [7:0] REASON_NONE = 8'h00;
	// Step codes.
	localparam logic [2:0] STEP_ARB = 3'h0;
	localparam logic [2:0] STEP_ONE_MSG = 3'h1;
	localparam logic [2:0] STEP_MSG_DONE = 3'h2;
	localparam logic [2:0] STEP_IN_CMD = 3'h3;
	localparam logic [2:0] STEP_ALL = 3'h4;
	// Field positions in the step and interrupt registers, and the three-byte message count.
	localparam int SOF_BIT = 3;
	localparam int IRQ_BITS = 2;
	localparam int IRQ_FINISH = 0;
	localparam int IRQ_DISC = 1;
	localparam logic [1:0] MSG_COUNT_THREE = 2'h3;
	// Bus phase as carried on the control lines.
	typedef struct packed {
		logic msg;
		logic cd;
		logic io;
	} ssd_phase_t;
	localparam ssd_phase_t PHASE_MSG_OUT = 3'h6;
	localparam ssd_phase_t PHASE_COMMAND = 3'h2;
	typedef enum logic [1:0] {
		SEL_PLAIN,
		SEL_ATN,
		SEL_THREE_MESSAGE_BYTE_SELECT,
		SEL_ATN_STOP
	} ssd_kind_t;
	typedef enum {
		ST_IDLE,
		ST_ARB,
		ST_WAIT_MSGOUT,
		ST_MSG_OUT,
		ST_WAIT_CMD,
		ST_CMD
	} ssd_state_t;
endpackage

// ===== ssd_top.sv
// Selection sequence status decode: step tracking, reason code and register slave.
// Assumes the sequencer strobes are on REF_CLK_IN; the bus phase lines come from pins.
//
// The Wishbone slave port was left to the implementer.
module ssd_top #(
	parameter int OFFSET_W = 4,
	parameter logic [3:0] OFFSET_MAX = 4'hF
) (
	// Clock and reset.
	input wire logic REF_CLK_IN,
	input wire logic RST_IN,
	// Wishbone slave.
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [31:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// Sequencer strobes.
	input wire logic SEQ_START_IN,
	input wire ssd_pkg::ssd_kind_t SEQ_KIND_IN,
	input wire logic SEL_DONE_IN,
	input wire logic SEL_TIMEOUT_IN,
	input wire logic DISCONNECT_IN,
	input wire logic PHASE_TIMEOUT_IN,
	input wire logic MSG_BYTE_SENT_IN,
	input wire logic CMD_BYTE_SENT_IN,
	input wire logic CMD_LAST_IN,
	input wire logic OFFSET_INC_IN,
	input wire logic OFFSET_DEC_IN,
	// Bus phase lines.
	input wire ssd_pkg::ssd_phase_t PHASE_IN,
	// Outputs.
	output logic ATN_OUT,
	output logic BUSY_OUT,
	output logic IRQ_OUT
);
	ssd_pkg::ssd_phase_t phase_meta_q, phase_q;
	ssd_pkg::ssd_state_t state_q;
	ssd_pkg::ssd_kind_t kind_q;
	logic [2:0] step_q;
	logic [7:0] reason_q;
	logic [1:0] msg_cnt_q;
	logic [OFFSET_W-1:0] offset_q;
	logic sof_n_q;
	logic [ssd_pkg::IRQ_BITS-1:0] irq_stat_q, irq_en_q;
	logic bus_req, bus_rd, bus_wr, reason_rd;
	logic [ssd_pkg::IDX_W-1:0] idx;
	logic finish;
	logic [7:0] fin_reason;
	logic [2:0] fin_step;
	logic step_set;
	logic [2:0] step_new;
	logic start_take;
	logic last_msg;
	logic clr_hit;
	logic [ssd_pkg::IRQ_BITS-1:0] irq_clr, irq_set;

	function automatic logic [31:0] pad8(input logic [7:0] v);
		return {24'h000000, v};
	endfunction

	// True when the byte just sent is the last one that this kind carries under attention.
	// The three-byte kind keeps attention up until its third byte has gone out.
	function automatic logic is_last_msg(input ssd_pkg::ssd_kind_t k, input logic [1:0] cnt);
		return k != ssd_pkg::SEL_THREE_MESSAGE_BYTE_SELECT || cnt + 2'h1 == ssd_pkg::MSG_COUNT_THREE;
	endfunction

	// A start strobe is only taken while idle; a strobe during a sequence is ignored.
	assign start_take = state_q == ssd_pkg::ST_IDLE && SEQ_START_IN;
	assign last_msg = is_last_msg(kind_q, msg_cnt_q);

	// Phase lines cross from the pins through two flops.
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			phase_meta_q <= '0;
			phase_q <= '0;
		end else begin
			phase_meta_q <= PHASE_IN;
			phase_q <= phase_meta_q;
		end
	end

	assign bus_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
	assign bus_rd = bus_req & ~WB_WE_IN;
	assign bus_wr = bus_req & WB_WE_IN & WB_SEL_IN[0];
	assign idx = WB_ADR_IN[ssd_pkg::ADDR_LSB +: ssd_pkg::IDX_W];
	assign reason_rd = bus_rd && idx == ssd_pkg::IDX_REASON;

	// Sequence walk. The target must follow message-out with command phase.
	always_comb begin
		finish = 1'b0;
		fin_reason = ssd_pkg::REASON_DONE;
		fin_step = step_q;
		step_set = 1'b0;
		step_new = step_q;
		if (state_q != ssd_pkg::ST_IDLE && (DISCONNECT_IN || SEL_TIMEOUT_IN)) begin
			finish = 1'b1;
			fin_reason = ssd_pkg::REASON_DISC;
			fin_step = ssd_pkg::STEP_ARB;
		end else begin
			unique case (state_q)
				ssd_pkg::ST_IDLE: begin
				end
				ssd_pkg::ST_ARB: begin
					if (SEL_DONE_IN && kind_q == ssd_pkg::SEL_PLAIN) begin
						step_set = 1'b1;
						step_new = ssd_pkg::STEP_MSG_DONE;
					end
				end
				ssd_pkg::ST_WAIT_MSGOUT: begin
					if (PHASE_TIMEOUT_IN) begin
						finish = 1'b1;
						fin_step = ssd_pkg::STEP_ARB;
					end
				end
				ssd_pkg::ST_MSG_OUT: begin
					if (MSG_BYTE_SENT_IN && kind_q == ssd_pkg::SEL_ATN_STOP) begin
						finish = 1'b1;
						fin_step = ssd_pkg::STEP_ONE_MSG;
					end else if (MSG_BYTE_SENT_IN) begin
						step_set = 1'b1;
						step_new = ssd_pkg::STEP_MSG_DONE;
					end else if (phase_q != ssd_pkg::PHASE_MSG_OUT) begin
						finish = 1'b1;
						fin_step = ssd_pkg::STEP_MSG_DONE;
					end
				end
				ssd_pkg::ST_WAIT_CMD: begin
					if (phase_q == ssd_pkg::PHASE_COMMAND) begin
						step_set = 1'b1;
						step_new = ssd_pkg::STEP_IN_CMD;
					end else if (PHASE_TIMEOUT_IN) begin
						finish = 1'b1;
						fin_step = ssd_pkg::STEP_MSG_DONE;
					end
				end
				ssd_pkg::ST_CMD: begin
					if (CMD_BYTE_SENT_IN && CMD_LAST_IN) begin
						finish = 1'b1;
						fin_step = ssd_pkg::STEP_ALL;
					end else if (phase_q != ssd_pkg::PHASE_COMMAND) begin
						finish = 1'b1;
						fin_step = ssd_pkg::STEP_IN_CMD;
					end
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			state_q <= ssd_pkg::ST_IDLE;
			kind_q <= ssd_pkg::SEL_PLAIN;
			msg_cnt_q <= '0;
		end else if (finish) begin
			state_q <= ssd_pkg::ST_IDLE;
		end else begin
			unique case (state_q)
				ssd_pkg::ST_IDLE: begin
					if (SEQ_START_IN) begin
						state_q <= ssd_pkg::ST_ARB;
						kind_q <= SEQ_KIND_IN;
						msg_cnt_q <= '0;
					end
				end
				ssd_pkg::ST_ARB: begin
					if (SEL_DONE_IN) begin
						state_q <= (kind_q == ssd_pkg::SEL_PLAIN) ? ssd_pkg::ST_WAIT_CMD
							: ssd_pkg::ST_WAIT_MSGOUT;
					end
				end
				ssd_pkg::ST_WAIT_MSGOUT: begin
					if (phase_q == ssd_pkg::PHASE_MSG_OUT) begin
						state_q <= ssd_pkg::ST_MSG_OUT;
					end
				end
				ssd_pkg::ST_MSG_OUT: begin
					if (MSG_BYTE_SENT_IN) begin
						msg_cnt_q <= msg_cnt_q + 2'h1;
						if (last_msg) begin
							state_q <= ssd_pkg::ST_WAIT_CMD;
						end
					end
				end
				ssd_pkg::ST_WAIT_CMD: begin
					if (phase_q == ssd_pkg::PHASE_COMMAND) begin
						state_q <= ssd_pkg::ST_CMD;
					end
				end
				ssd_pkg::ST_CMD: begin
				end
			endcase
		end
	end

	// Attention rises with a non-plain sequence; it drops after the last message byte (not for the stop kind) or on a reason read while idle.
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			ATN_OUT <= 1'b0;
		end else if (start_take) begin
			ATN_OUT <= SEQ_KIND_IN != ssd_pkg::SEL_PLAIN;
		end else if (state_q == ssd_pkg::ST_MSG_OUT && MSG_BYTE_SENT_IN &&
			kind_q != ssd_pkg::SEL_ATN_STOP) begin
			if (last_msg) begin
				ATN_OUT <= 1'b0;
			end
		end else if (state_q == ssd_pkg::ST_IDLE && reason_rd) begin
			// Attention left standing by a halt is dropped once software has seen why.
			ATN_OUT <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			BUSY_OUT <= 1'b0;
		end else begin
			BUSY_OUT <= (state_q != ssd_pkg::ST_IDLE && !finish) || start_take;
		end
	end

	// Step and reason registers; a new value wins over a clearing read.
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			step_q <= ssd_pkg::STEP_ARB;
			reason_q <= ssd_pkg::REASON_NONE;
		end else if (finish) begin
			step_q <= fin_step;
			reason_q <= fin_reason;
		end else if (step_set) begin
			step_q <= step_new;
		end else if (start_take) begin
			step_q <= ssd_pkg::STEP_ARB;
		end else if (reason_rd) begin
			step_q <= ssd_pkg::STEP_ARB;
			reason_q <= ssd_pkg::REASON_NONE;
		end
	end

	// Offset counter; the flag is stored inverted so it reads low at the limit.
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			offset_q <= '0;
			sof_n_q <= 1'b1;
		end else begin
			if (OFFSET_INC_IN && !OFFSET_DEC_IN && offset_q != OFFSET_MAX[OFFSET_W-1:0]) begin
				offset_q <= offset_q + 1'b1;
				sof_n_q <= (offset_q + 1'b1) != OFFSET_MAX[OFFSET_W-1:0];
			end else if (OFFSET_DEC_IN && !OFFSET_INC_IN && offset_q != '0) begin
				offset_q <= offset_q - 1'b1;
				sof_n_q <= 1'b1;
			end
		end
	end

	// Clear mask from a write to the clear register; set bits come from this cycle's finish.
	assign clr_hit = bus_wr && idx == ssd_pkg::IDX_IRQ_CLR;
	assign irq_clr = clr_hit ? WB_DAT_IN[ssd_pkg::IRQ_BITS-1:0] : '0;

	always_comb begin
		irq_set = '0;
		irq_set[ssd_pkg::IRQ_FINISH] = finish;
		irq_set[ssd_pkg::IRQ_DISC] = finish && fin_reason == ssd_pkg::REASON_DISC;
	end

	// Interrupt status: set wins over a clear in the same cycle, so no finish is lost.
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			irq_stat_q <= '0;
			irq_en_q <= '0;
		end else begin
			if (bus_wr && idx == ssd_pkg::IDX_IRQ_EN) begin
				irq_en_q <= WB_DAT_IN[ssd_pkg::IRQ_BITS-1:0];
			end
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= |(irq_stat_q & irq_en_q);
		end
	end

	// Bus slave answers one cycle after the request; unmapped reads return zero.
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= '0;
		end else begin
			WB_ACK_OUT <= bus_req;
			if (bus_rd) begin
				unique case (idx)
					ssd_pkg::IDX_REASON: WB_DAT_OUT <= pad8(reason_q);
					ssd_pkg::IDX_STEP: WB_DAT_OUT <= pad8({4'h0, sof_n_q, step_q});
					ssd_pkg::IDX_IRQ_STAT: WB_DAT_OUT <= {30'h0, irq_stat_q};
					ssd_pkg::IDX_IRQ_EN: WB_DAT_OUT <= {30'h0, irq_en_q};
					default: WB_DAT_OUT <= '0;
				endcase
			end
		end
	end
endmodule

// ===== ssd_target.sv
// Behavioural SCSI target facing the selection sequencer.
// Assumes the bench says whether it enters message-out and command phase.
module ssd_target (
	// Clock and control.
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sel_in,
	input wire logic busy_in,
	input wire logic want_msg_in,
	input wire logic want_cmd_in,
	// Bus lines.
	input wire logic atn_in,
	output ssd_pkg::ssd_phase_t phase_out
);
	logic atn_q;
	// Released lines read as deasserted, so an idle bus shows all zero.
	always_ff @(posedge clk_in) begin
		atn_q <= atn_in;
		if (rst_in || !busy_in) begin
			phase_out <= 3'h0;
		end else if (sel_in) begin
			phase_out <= want_msg_in ? ssd_pkg::PHASE_MSG_OUT :
				want_cmd_in ? ssd_pkg::PHASE_COMMAND : 3'h1;
		end else if (phase_out == ssd_pkg::PHASE_MSG_OUT && atn_q && !atn_in && want_cmd_in) begin
			phase_out <= ssd_pkg::PHASE_COMMAND;
		end
	end
endmodule

// ===== ssd_checker.sv
// Assertions on the ports of the selection sequence status decode block.
// Assumes the sequencer strobes arrive only in the states that expect them.
module ssd_checker (
	// Clock, reset and bus.
	input wire logic REF_CLK_IN,
	input wire logic RST_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic WB_ACK_OUT,
	// Sequencer and outputs.
	input wire logic SEQ_START_IN,
	input wire ssd_pkg::ssd_kind_t SEQ_KIND_IN,
	input wire logic SEL_TIMEOUT_IN,
	input wire logic DISCONNECT_IN,
	input wire logic MSG_BYTE_SENT_IN,
	input wire logic CMD_BYTE_SENT_IN,
	input wire logic CMD_LAST_IN,
	input wire logic ATN_OUT,
	input wire logic BUSY_OUT
);
	ssd_pkg::ssd_kind_t kind_q;
	logic [1:0] msgs_q;
	// The kind port only qualifies the start strobe, so it is kept here.
	always_ff @(posedge REF_CLK_IN) begin
		if (SEQ_START_IN && !BUSY_OUT) begin
			kind_q <= SEQ_KIND_IN;
			msgs_q <= 2'h0;
		end else if (MSG_BYTE_SENT_IN && msgs_q != 2'h3) begin
			msgs_q <= msgs_q + 2'h1;
		end
	end
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (RST_IN);
	a_ack_answer:
		assert property (WB_ACK_OUT == $past(WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT))
		else $error("ack timing wrong");
	a_upper_zero:
		assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h0) else $error("upper data set");
	a_start_busy:
		assert property (SEQ_START_IN && !BUSY_OUT |=> BUSY_OUT) else $error("start not taken");
	a_fail_ends:
		assert property (BUSY_OUT && (DISCONNECT_IN || SEL_TIMEOUT_IN) |=> !BUSY_OUT)
		else $error("disconnect did not end");
	a_plain_done:
		assert property (BUSY_OUT && kind_q == ssd_pkg::SEL_PLAIN && CMD_BYTE_SENT_IN
			&& CMD_LAST_IN |=> !BUSY_OUT && !ATN_OUT) else $error("plain did not finish");
	a_atn_release:
		assert property (BUSY_OUT && kind_q == ssd_pkg::SEL_ATN && MSG_BYTE_SENT_IN |=> !ATN_OUT)
		else $error("attention kept");
	a_stop_hold:
		assert property (BUSY_OUT && kind_q == ssd_pkg::SEL_ATN_STOP && MSG_BYTE_SENT_IN
			|=> (!BUSY_OUT && ATN_OUT) [*2]) else $error("stop wrong");
	a_three_hold:
		assert property (BUSY_OUT && kind_q == ssd_pkg::SEL_THREE_MESSAGE_BYTE_SELECT && ATN_OUT && !DISCONNECT_IN
			&& !SEL_TIMEOUT_IN && !(msgs_q == 2'h3 || (msgs_q == 2'h2 && MSG_BYTE_SENT_IN))
			|=> ATN_OUT) else $error("attention dropped early");
endmodule
bind ssd_top ssd_checker chk_u (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN),
	.WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_DAT_OUT(WB_DAT_OUT),
	.WB_ACK_OUT(WB_ACK_OUT), .SEQ_START_IN(SEQ_START_IN), .SEQ_KIND_IN(SEQ_KIND_IN),
	.SEL_TIMEOUT_IN(SEL_TIMEOUT_IN), .DISCONNECT_IN(DISCONNECT_IN),
	.MSG_BYTE_SENT_IN(MSG_BYTE_SENT_IN), .CMD_BYTE_SENT_IN(CMD_BYTE_SENT_IN),
	.CMD_LAST_IN(CMD_LAST_IN), .ATN_OUT(ATN_OUT), .BUSY_OUT(BUSY_OUT));

// ===== ssd_top_tb_top.sv
// Self-checking bench for the selection sequence status decode block.
// Assumes ssd_target on the bus side; t_sof walks the offset counter up to its limit and back down one.
module ssd_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] wd = 32'h0;
	logic [7:0] ev_q = 8'h00;
	logic [1:0] kind = 2'h0;
	logic wm = 1'b0;
	logic wc = 1'b0;
	logic inc = 1'b0;
	logic dec = 1'b0;
	logic [31:0] rdat;
	logic ack, atn, busy, irq;
	ssd_pkg::ssd_phase_t phase;
	int failures = 0;
	int n_checks = 0;
	initial forever #25 clk = ~clk;
	ssd_top dut_u (.REF_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(cyc),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wd), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .SEQ_START_IN(ev_q[7]), .SEQ_KIND_IN(ssd_pkg::ssd_kind_t'(kind)),
		.SEL_DONE_IN(ev_q[6]), .SEL_TIMEOUT_IN(ev_q[5]), .DISCONNECT_IN(ev_q[4]),
		.PHASE_TIMEOUT_IN(ev_q[3]), .MSG_BYTE_SENT_IN(ev_q[2]), .CMD_BYTE_SENT_IN(ev_q[1]),
		.CMD_LAST_IN(ev_q[0]), .OFFSET_INC_IN(inc), .OFFSET_DEC_IN(dec), .PHASE_IN(phase),
		.ATN_OUT(atn), .BUSY_OUT(busy), .IRQ_OUT(irq));
	ssd_target tgt_u (.clk_in(clk), .rst_in(rst), .sel_in(ev_q[6]), .busy_in(busy),
		.want_msg_in(wm), .want_cmd_in(wc), .atn_in(atn), .phase_out(phase));
	task wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wb(input logic w, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= {26'h0, idx, 2'h0};
		wd <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			wrap_up();
		end
		q = rdat[7:0];
		cyc <= 1'b0;
	endtask
	task rd(input logic [3:0] idx, input logic [7:0] exp, input string what);
		logic [7:0] q;
		wb(1'b0, idx, 8'h00, q);
		chk(what, exp, q);
	endtask
	task wr(input logic [3:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, idx, d, q);
	endtask
	// The fixed wait covers the two-flop phase synchroniser and the target's reply.
	task ev(input logic [7:0] m);
		@(posedge clk);
		ev_q <= m;
		@(posedge clk);
		ev_q <= 8'h00;
		repeat (5) @(posedge clk);
	endtask
	task run(input logic [1:0] k, input logic m, input logic c);
		kind <= k;
		wm <= m;
		wc <= c;
		ev(8'h80);
		ev(8'h40);
	endtask
	task fin(input logic [7:0] step, input logic [7:0] why, input string what);
		rd(4'h6, step | 8'h08, what);
		rd(4'h5, why, what);
		rd(4'h6, 8'h08, what);
		$display("done %s", what);
	endtask
	task t_plain();
		run(2'h0, 1'b0, 1'b1);
		chk("busy", 8'h01, {7'h0, busy});
		ev(8'h03);
		chk("busy", 8'h00, {7'h0, busy});
		fin(8'h04, 8'h18, "plain");
	endtask
	task t_nocmd();
		run(2'h0, 1'b0, 1'b0);
		ev(8'h08);
		fin(8'h02, 8'h18, "no command");
	endtask
	task t_disc();
		run(2'h0, 1'b0, 1'b1);
		ev(8'h10);
		fin(8'h00, 8'h20, "disconnect");
	endtask
	task t_atn();
		run(2'h1, 1'b1, 1'b1);
		ev(8'h04);
		chk("atn", 8'h00, {7'h0, atn});
		ev(8'h03);
		fin(8'h04, 8'h18, "atn");
	endtask
	task t_nomsg();
		run(2'h1, 1'b0, 1'b0);
		ev(8'h08);
		chk("atn", 8'h01, {7'h0, atn});
		fin(8'h00, 8'h18, "no msg");
		chk("atn", 8'h00, {7'h0, atn});
	endtask
	task t_three(input logic c, input logic [7:0] e, input logic [7:0] s);
		run(2'h2, 1'b1, c);
		repeat (3) ev(8'h04);
		chk("atn", 8'h00, {7'h0, atn});
		ev(e);
		fin(s, 8'h18, "three");
	endtask
	task t_stop();
		run(2'h3, 1'b1, 1'b0);
		ev(8'h04);
		chk("atn", 8'h01, {7'h0, atn});
		fin(8'h01, 8'h18, "stop");
	endtask
	task t_irq();
		wr(4'hA, 8'h02);
		kind <= 2'h0;
		ev(8'h80);
		ev(8'h20);
		chk("irq", 8'h01, {7'h0, irq});
		wr(4'hA, 8'h00);
		repeat (2) @(posedge clk);
		chk("irq", 8'h00, {7'h0, irq});
		wr(4'h9, 8'h03);
		rd(4'h8, 8'h00, "status");
		fin(8'h00, 8'h20, "timeout");
	endtask
	// Fifteen increments bring the counter from zero to its limit.
	task t_sof();
		@(posedge clk);
		inc <= 1'b1;
		repeat (15) @(posedge clk);
		inc <= 1'b0;
		rd(4'h6, 8'h00, "offset max");
		@(posedge clk);
		dec <= 1'b1;
		@(posedge clk);
		dec <= 1'b0;
		rd(4'h6, 8'h08, "offset below max");
		$display("done offset");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(4'h6, 8'h08, "step");
		rd(4'h5, 8'h00, "reason");
		rd(4'h3, 8'h00, "unmapped");
		t_plain();
		t_nocmd();
		t_disc();
		t_atn();
		t_nomsg();
		t_three(1'b1, 8'h03, 8'h04);
		t_three(1'b0, 8'h08, 8'h02);
		t_stop();
		t_irq();
		t_sof();
		wrap_up();
	end
endmodule
